// ---- hdl/axis_homing_sequencer.sv ----
/*
 * Homing sequencer for one servo axis: runs the selected method, commands
 * speed and direction to the motion controller, defines the zero point.
 * Assumes the motion controller follows speed_cmd and reports position.
 */
// Operation
// RULE1: Method number signed, negatives vendor, 0..35 standard
// RULE2: Speed one for search, two for index
// RULE3: Speed pair entry 0 search, 1 index
// RULE4: Leaving max travel stops axis, overrun error; the code skips this check for block methods, in BACKOFF, and when travel is 0
// RULE5: Mark input selectable from two fast inputs
// RULE6: Limit switch from function 5 or 6
// RULE7: Cam from digital input function 10; decoded on inputs b and c only
// RULE8: Method -13 loads position with offset
// RULE9: Method -5 sets encoder position plus offset
// RULE10: Method -12 stores reference, restores at start
// RULE11: Block methods suppress following-error monitoring
// RULE12: Block run uses homing torque scale 0..100
// RULE13: Homing torque scale only for block methods
// RULE14: Methods -10/-11 block, reverse, first zero pulse
// RULE15: Methods -8/-9 travel value is block threshold
// RULE16: Block without pulse backs off half travel
// RULE17: Zero point gets programmed offset applied
// RULE18: Relative moves allowed without homing
// RULE19: Done flag set on success, cleared otherwise
`timescale 1ns/100ps
module axis_homing_sequencer #(
    parameter int POS_W = homing_pkg::POS_W,
    parameter int SPD_W = homing_pkg::SPD_W
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic homing_start,
    input wire logic power_up_start,
    input wire logic signed [homing_pkg::METHOD_W-1:0] homing_method_select,
    input wire logic [SPD_W-1:0] switch_search_speed,
    input wire logic [SPD_W-1:0] zero_pulse_search_speed,
    input wire logic [SPD_W-1:0] homing_acceleration,
    input wire logic [POS_W-1:0] homing_max_travel,
    input wire logic signed [POS_W-1:0] home_offset_value,
    input wire logic [homing_pkg::SCALE_W-1:0] homing_torque_scale,
    input wire logic [homing_pkg::SCALE_W-1:0] normal_torque_scale,
    input wire logic mark_select,
    input wire logic fast_input_a,
    input wire logic fast_input_b,
    input wire logic digital_input_c,
    input wire logic [homing_pkg::FUNC_W-1:0] input_a_function,
    input wire logic [homing_pkg::FUNC_W-1:0] input_b_function,
    input wire logic [homing_pkg::FUNC_W-1:0] input_c_function,
    input wire logic zero_pulse,
    input wire logic signed [POS_W-1:0] actual_position,
    input wire logic signed [POS_W-1:0] absolute_encoder_position,
    input wire logic signed [POS_W-1:0] following_error,
    input wire logic absolute_move_req,
    output logic homing_active,
    output logic signed [SPD_W:0] speed_cmd,
    output logic [SPD_W-1:0] accel_cmd,
    output logic [homing_pkg::SCALE_W-1:0] torque_scale_cmd,
    output logic follow_error_enable,
    output logic position_load,
    output logic signed [POS_W-1:0] position_load_value,
    output logic [POS_W-1:0] homing_backup_position,
    output logic homing_done,
    output logic overrun_error,
    output logic absolute_move_allowed
);
    import homing_pkg::*;

    // ==========================================
    // Helper functions
    // Absolute value of a signed position
    function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
        mag = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
    endfunction

    // Block methods (with or without zero pulse)
    function automatic logic is_block(input logic signed [7:0] m);
        is_block = (m == M_BLOCK_NEG) || (m == M_BLOCK_POS) || (m == M_BLOCK_ZP_NEG) || (m == M_BLOCK_ZP_POS);
    endfunction

    // ==========================================
    // Input synchronisation
    logic [3:0] in_level; // zero pulse, a, b, c
    logic [3:0] in_rise;
    logic [3:0] in_fall;

    homing_input_capture #(.N(4)) u_capture (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in({digital_input_c, fast_input_b, fast_input_a, zero_pulse}),
        .level(in_level),
        .rise(in_rise),
        .fall(in_fall)
    );

    // ==========================================
    // Signal routing by function code
    logic pos_limit; // Positive limit switch level
    logic neg_limit; // Negative limit switch level
    logic cam_level; // Reference cam level
    logic cam_fall; // Cam falling edge
    logic limit_fall; // Limit switch falling edge
    logic zp_rise; // Zero pulse or selected mark edge

    always_comb begin
        // RULE6: limit function decode
        pos_limit = (input_a_function == FUNC_POS_LIMIT && in_level[1])
                  || (input_b_function == FUNC_POS_LIMIT && in_level[2])
                  || (input_c_function == FUNC_POS_LIMIT && in_level[3]);
        neg_limit = (input_a_function == FUNC_NEG_LIMIT && in_level[1])
                  || (input_b_function == FUNC_NEG_LIMIT && in_level[2])
                  || (input_c_function == FUNC_NEG_LIMIT && in_level[3]);
        limit_fall = ((input_a_function == FUNC_POS_LIMIT || input_a_function == FUNC_NEG_LIMIT) && in_fall[1])
                   || ((input_b_function == FUNC_POS_LIMIT || input_b_function == FUNC_NEG_LIMIT) && in_fall[2])
                   || ((input_c_function == FUNC_POS_LIMIT || input_c_function == FUNC_NEG_LIMIT) && in_fall[3]);
        // RULE7: cam function decode
        cam_level = (input_b_function == FUNC_REF_CAM && in_level[2])
                  || (input_c_function == FUNC_REF_CAM && in_level[3]);
        cam_fall = (input_b_function == FUNC_REF_CAM && in_fall[2])
                 || (input_c_function == FUNC_REF_CAM && in_fall[3]);
        // RULE5: mark from fast input a or b
        zp_rise = in_rise[0] || (mark_select ? in_rise[2] : in_rise[1]);
    end

    // ==========================================
    // Sequencer state
    typedef enum logic [2:0] {IDLE, SEARCH, REVERSE, INDEX, BACKOFF, FINISH, FAULT} state_t;
    state_t state;
    state_t next_state;
    logic dir_neg; // Travel direction negative
    logic next_dir_neg;
    logic signed [POS_W-1:0] start_pos; // Position at run start
    logic signed [POS_W-1:0] next_start_pos;
    logic signed [POS_W-1:0] backoff_pos; // Position at block detection
    logic signed [POS_W-1:0] next_backoff_pos;
    logic signed [7:0] method; // Latched method
    logic signed [7:0] next_method;
    logic done;
    logic next_done;
    logic err;
    logic next_err;
    logic load;
    logic next_load;
    logic signed [POS_W-1:0] load_val;
    logic signed [POS_W-1:0] next_load_val;
    logic [POS_W-1:0] backup;
    logic [POS_W-1:0] next_backup;
    logic backup_valid; // Reference stored by method -12
    logic next_backup_valid;
    logic [POS_W-1:0] travel; // Distance from start
    logic block_hit; // Following error reached threshold

    always_comb begin
        travel = mag(POS_W'(actual_position - start_pos));
        // RULE15: travel value is the block threshold
        block_hit = mag(following_error) >= homing_max_travel;
    end

    // Next-state logic
    always_comb begin
        next_state = state;
        next_dir_neg = dir_neg;
        next_start_pos = start_pos;
        next_backoff_pos = backoff_pos;
        next_method = method;
        next_done = done;
        next_err = err;
        next_load = 1'b0;
        next_load_val = load_val;
        next_backup = backup;
        next_backup_valid = backup_valid;
        unique case (state)
            IDLE: begin
                if (homing_start) begin
                    next_method = homing_method_select;
                    next_start_pos = actual_position;
                    // RULE19: clear done while running
                    next_done = 1'b0;
                    next_err = 1'b0;
                    // RULE1: vendor negatives, standard 0..35
                    if (homing_method_select < M_ABS_OFFSET || homing_method_select > M_STD_LAST) begin
                        next_state = FAULT;
                    end else begin
                        next_dir_neg = (homing_method_select == M_BLOCK_NEG)
                                     || (homing_method_select == M_BLOCK_ZP_NEG)
                                     || (homing_method_select == M_SWITCH_NEG)
                                     || (homing_method_select == M_CAM_NEG);
                        if (homing_method_select == M_ABS_OFFSET || homing_method_select == M_ABS_ENCODER
                            || homing_method_select == M_SET_REFERENCE || homing_method_select < M_STD_FIRST
                            && !is_block(homing_method_select)) begin
                            next_state = FINISH;
                        end else begin
                            next_state = SEARCH;
                        end
                    end
                end else if (power_up_start && backup_valid) begin
                    // RULE10: restore reference at start
                    next_load = 1'b1;
                    next_load_val = actual_position - $signed(backup) + home_offset_value;
                    next_done = 1'b1;
                end
            end
            SEARCH: begin
                if (is_block(method) ? block_hit
                    : ((method == M_SWITCH_NEG || method == M_SWITCH_POS) ? (pos_limit || neg_limit) : cam_level)) begin
                    next_backoff_pos = actual_position;
                    next_dir_neg = ~dir_neg;
                    // RULE16: block without pulse backs off
                    next_state = (method == M_BLOCK_NEG || method == M_BLOCK_POS) ? BACKOFF : REVERSE;
                end
            end
            REVERSE: begin
                // RULE14: zero pulse taken after reversal
                if (is_block(method) || limit_fall || cam_fall) begin
                    next_state = INDEX;
                end
            end
            INDEX: begin
                if (zp_rise) begin
                    next_state = FINISH;
                end
            end
            BACKOFF: begin
                // RULE16: half the travel value
                if (mag(POS_W'(actual_position - backoff_pos)) >= (homing_max_travel >> 1)) begin
                    next_state = FINISH;
                end
            end
            FINISH: begin
                next_load = 1'b1;
                next_done = 1'b1;
                next_state = IDLE;
                if (method == M_ABS_OFFSET) begin
                    // RULE8: position equals offset
                    next_load_val = home_offset_value;
                end else if (method == M_ABS_ENCODER) begin
                    // RULE9: encoder plus offset
                    next_load_val = absolute_encoder_position + home_offset_value;
                end else if (method == M_SET_REFERENCE) begin
                    // RULE10: store machine reference
                    next_backup = actual_position;
                    next_backup_valid = 1'b1;
                    next_load_val = home_offset_value;
                end else begin
                    // RULE17: zero point takes offset
                    next_load_val = home_offset_value;
                end
            end
            FAULT: begin
                next_state = IDLE;
            end
        endcase
        // RULE4: overrun stops the axis
        if ((state == SEARCH || state == REVERSE || state == INDEX) && !is_block(method)
            && homing_max_travel != '0 && travel > homing_max_travel) begin
            next_state = FAULT;
        end
        if (next_state == FAULT) begin
            next_err = 1'b1;
            next_done = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= IDLE;
            dir_neg <= RESET_DIR[0];
            start_pos <= '0;
            backoff_pos <= '0;
            method <= '0;
            done <= 1'b0;
            err <= 1'b0;
            load <= 1'b0;
            load_val <= '0;
            backup <= '0;
            backup_valid <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            dir_neg <= next_dir_neg;
            start_pos <= next_start_pos;
            backoff_pos <= next_backoff_pos;
            method <= next_method;
            done <= next_done;
            err <= next_err;
            load <= next_load;
            load_val <= next_load_val;
            backup <= next_backup;
            backup_valid <= next_backup_valid;
        end
    end

    // ==========================================
    // Motion commands
    logic moving;
    logic [SPD_W-1:0] spd;

    always_comb begin
        moving = (state == SEARCH) || (state == REVERSE) || (state == INDEX) || (state == BACKOFF);
        // RULE2: search speed then index speed
        // RULE3: pair entry select
        spd = (state == INDEX) ? zero_pulse_search_speed : switch_search_speed;
        speed_cmd = !moving ? '0 : dir_neg ? -$signed({1'b0, spd}) : $signed({1'b0, spd});
        // RULE2: common acceleration
        accel_cmd = homing_acceleration;
        // RULE12: block run torque scale
        // RULE13: only for block methods
        torque_scale_cmd = (moving && is_block(method))
                         ? ((homing_torque_scale > SCALE_MAX) ? SCALE_MAX : homing_torque_scale)
                         : normal_torque_scale;
        // RULE11: monitoring off in block runs
        follow_error_enable = !(homing_active && is_block(method));
    end

    assign homing_active = state != IDLE;
    assign position_load = load;
    assign position_load_value = load_val;
    assign homing_backup_position = backup;
    assign homing_done = done;
    assign overrun_error = err;
    // RULE18: absolute moves need homing
    assign absolute_move_allowed = !absolute_move_req || done;

    // ==========================================
    // Assertions
    sequence run_start_s;
        state == IDLE && homing_start && clk_en;
    endsequence

    done_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE19
        run_start_s |=> !homing_done) else $error("done not cleared on start");
    fault_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
        state == FAULT |-> overrun_error && !homing_done) else $error("fault without error");
    stop_fault_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
        state == FAULT |-> speed_cmd == 0) else $error("axis moving in fault");
    torque_sel_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE13
        !is_block(method) |-> torque_scale_cmd == normal_torque_scale) else $error("wrong torque scale");
    fe_off_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE11
        homing_active && is_block(method) |-> !follow_error_enable) else $error("monitoring left on");
    speed_index_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
        state == INDEX |-> speed_cmd == $signed({1'b0, zero_pulse_search_speed})
        || speed_cmd == -$signed({1'b0, zero_pulse_search_speed})) else $error("wrong index speed");
    abs13_load_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
        state == FINISH && method == M_ABS_OFFSET && clk_en |=> position_load
        && position_load_value == $past(home_offset_value)) else $error("bad -13 load");
    abs5_load_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE9
        state == FINISH && method == M_ABS_ENCODER && clk_en |=> position_load
        && position_load_value == $past(absolute_encoder_position) + $past(home_offset_value))
        else $error("bad -5 load");
    abs_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE18
        absolute_move_req && !homing_done |-> !absolute_move_allowed) else $error("absolute move unhomed");
endmodule

// ---- hdl/homing_pkg.sv ----
/*
 * Constants shared by the axis homing sequencer and its testbench.
 * Assumes positions in signed 32-bit units, speeds in 16-bit units.
 */
package homing_pkg;
    // ==========================================
    // Widths
    localparam int POS_W = 32;
    localparam int SPD_W = 16;
    localparam int METHOD_W = 8;
    localparam int FUNC_W = 4;
    localparam int SCALE_W = 7;
    // ==========================================
    // Method numbers
    localparam logic signed [7:0] M_ABS_OFFSET = -8'sd13;
    localparam logic signed [7:0] M_SET_REFERENCE = -8'sd12;
    localparam logic signed [7:0] M_BLOCK_ZP_POS = -8'sd11;
    localparam logic signed [7:0] M_BLOCK_ZP_NEG = -8'sd10;
    localparam logic signed [7:0] M_BLOCK_POS = -8'sd9;
    localparam logic signed [7:0] M_BLOCK_NEG = -8'sd8;
    localparam logic signed [7:0] M_ABS_ENCODER = -8'sd5;
    localparam logic signed [7:0] M_STD_FIRST = 8'sd0;
    localparam logic signed [7:0] M_STD_LAST = 8'sd35;
    localparam logic signed [7:0] M_SWITCH_NEG = 8'sd1;
    localparam logic signed [7:0] M_SWITCH_POS = 8'sd2;
    localparam logic signed [7:0] M_CAM_POS = 8'sd3;
    localparam logic signed [7:0] M_CAM_NEG = 8'sd4;
    // ==========================================
    // Digital input function codes
    localparam logic [3:0] FUNC_POS_LIMIT = 4'h5;
    localparam logic [3:0] FUNC_NEG_LIMIT = 4'h6;
    localparam logic [3:0] FUNC_REF_CAM = 4'ha;
    // ==========================================
    // Homing speed pair entries
    localparam int SPEED_SWITCH_IDX = 0;
    localparam int SPEED_INDEX_IDX = 1;
    // ==========================================
    // Torque scale limit and reset values
    localparam logic [6:0] SCALE_MAX = 7'h64;
    localparam logic [1:0] RESET_DIR = 2'h0;
endpackage

// ---- hdl/homing_input_capture.sv ----
/*
 * Synchronises the encoder zero pulse and the three digital inputs
 * and gives registered levels plus rising and falling edges.
 * Assumes all inputs are asynchronous pins.
 */
`timescale 1ns/100ps
module homing_input_capture #(
    parameter int N = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] level,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    // ==========================================
    // Two-stage synchroniser and edge history
    logic [N-1:0] sync_a; // First stage, read only by sync_b
    logic [N-1:0] sync_b; // Second stage
    logic [N-1:0] prev; // Delayed level for edges
    logic [N-1:0] next_sync_a;
    logic [N-1:0] next_sync_b;
    logic [N-1:0] next_prev;

    // Next values
    always_comb begin
        next_sync_a = pin_in;
        next_sync_b = sync_a;
        next_prev = sync_b;
    end

    // Register stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= '0;
            sync_b <= '0;
            prev <= '0;
        end else if (clk_en) begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            prev <= next_prev;
        end
    end

    // Level and edge outputs
    assign level = sync_b;
    assign rise = sync_b & ~prev;
    assign fall = ~sync_b & prev;
endmodule

// ---- verification/axis_plant_model.sv ----
/*
 * Plant model of the axis: integrates the speed command, stops at a hard
 * block, drives limit switches, cam and zero pulse from the actual position.
 * Assumes one position unit per speed unit and clock cycle.
 */
`timescale 1ns/100ps
module axis_plant_model #(
    parameter int LIMIT = 400,
    parameter int BLOCK = 600,
    parameter int CAM = 200
) (
    input wire logic core_clk,
    input wire logic zero_req,
    input wire logic signed [16:0] speed_cmd,
    output logic signed [31:0] actual_position,
    output logic signed [31:0] following_error,
    output logic pos_limit,
    output logic neg_limit,
    output logic cam,
    output logic zero_pulse
);
    // ==========================================
    // Commanded position, cleared between runs
    logic signed [31:0] cmd_pos = 32'sh0000_0000;
    always @(posedge core_clk) begin
        cmd_pos <= zero_req ? 32'sh0000_0000 : cmd_pos + 32'(speed_cmd);
    end
    // ==========================================
    // Hard block clamps the axis, the excess shows as following error
    assign actual_position = (cmd_pos > BLOCK) ? BLOCK : cmd_pos;
    assign following_error = cmd_pos - actual_position;
    // Switch, cam and zero pulse levels follow the position
    assign pos_limit = actual_position >= LIMIT;
    assign neg_limit = actual_position <= -LIMIT;
    assign cam = actual_position >= CAM;
    assign zero_pulse = actual_position[5:0] < 6'h08;
endmodule

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the axis homing sequencer, one task per scenario.
 * Assumes the plant model stands in for axis, switches, cam and zero pulse.
 */
`timescale 1ns/100ps
module tb_top;
    import homing_pkg::*;
    // ==========================================
    // Inputs, set at time zero
    logic core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, homing_start = 1'b0, power_up_start = 1'b0;
    logic mark_select = 1'b0, absolute_move_req = 1'b0, zero_req = 1'b0;
    logic signed [7:0] homing_method_select = 8'sh00;
    logic [15:0] switch_search_speed = 16'h0008, zero_pulse_search_speed = 16'h0002, homing_acceleration = 16'h0010;
    logic [31:0] homing_max_travel = 32'h0000_07d0, homing_backup_position;
    logic signed [31:0] home_offset_value = 32'sh0000_0100, absolute_encoder_position = 32'sh0000_1234;
    logic [6:0] homing_torque_scale = 7'h28, normal_torque_scale = 7'h50, torque_scale_cmd;
    logic [3:0] input_a_function = FUNC_POS_LIMIT, input_b_function = FUNC_NEG_LIMIT, input_c_function = FUNC_REF_CAM;
    // Outputs of the sequencer and the plant
    logic signed [31:0] actual_position, following_error, position_load_value;
    logic fast_input_a, fast_input_b, digital_input_c, zero_pulse, homing_active, follow_error_enable;
    logic position_load, homing_done, overrun_error, absolute_move_allowed;
    logic signed [16:0] speed_cmd;
    logic [15:0] accel_cmd;
    int fail_count = 0, check_count = 0, cycles = 0;
    axis_homing_sequencer u_axis_homing_sequencer (.core_clk, .arst_n, .clk_en, .homing_start, .power_up_start,
        .homing_method_select, .switch_search_speed, .zero_pulse_search_speed, .homing_acceleration,
        .homing_max_travel, .home_offset_value, .homing_torque_scale, .normal_torque_scale, .mark_select,
        .fast_input_a, .fast_input_b, .digital_input_c, .input_a_function, .input_b_function, .input_c_function,
        .zero_pulse, .actual_position, .absolute_encoder_position, .following_error, .absolute_move_req,
        .homing_active, .speed_cmd, .accel_cmd, .torque_scale_cmd, .follow_error_enable, .position_load,
        .position_load_value, .homing_backup_position, .homing_done, .overrun_error, .absolute_move_allowed);
    axis_plant_model u_axis_plant_model (.core_clk, .zero_req, .speed_cmd, .actual_position, .following_error,
        .pos_limit(fast_input_a), .neg_limit(fast_input_b), .cam(digital_input_c), .zero_pulse);
    // ==========================================
    // Clock and hang guard
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ==========================================
    // Shared helpers
    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [16:0] spd_mag();
        return speed_cmd[16] ? 17'(-speed_cmd) : 17'(speed_cmd);
    endfunction
    // Clears the plant except for method -12, then one start pulse; entered at a falling edge
    task automatic kick(input logic signed [7:0] m);
        zero_req = (m != M_SET_REFERENCE);
        @(negedge core_clk);
        zero_req = 1'b0;
        homing_method_select = m;
        homing_start = 1'b1;
        @(negedge core_clk);
        homing_start = 1'b0;
    endtask
    // Waits for the load pulse, noting whether index speed was used
    task automatic run_to_load(output bit seen_v2);
        seen_v2 = 1'b0;
        for (int i = 0; i < 3000 && position_load !== 1'b1; i++) begin
            if (spd_mag() === {1'b0, zero_pulse_search_speed}) seen_v2 = 1'b1;
            @(negedge core_clk);
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_absolute(input logic signed [7:0] m, input logic signed [31:0] exp_val);
        kick(m);
        chk(homing_active === 1'b1 && homing_done === 1'b0 && overrun_error === 1'b0, "run flags");
        @(negedge core_clk);
        chk(position_load === 1'b1 && position_load_value === exp_val, "absolute load value");
        chk(homing_done === 1'b1 && homing_active === 1'b0, "done flag");
        $display("test absolute %0d finished", m);
    endtask
    task automatic t_invalid();
        absolute_move_req = 1'b1;
        kick(-8'sd14);
        repeat (2) @(negedge core_clk);
        chk(overrun_error === 1'b1 && homing_done === 1'b0, "method out of range accepted");
        chk(absolute_move_allowed === 1'b0, "absolute move unhomed");
        $display("test invalid method finished");
    endtask
    task automatic t_search(input logic signed [7:0] m);
        bit v2;
        homing_max_travel = 32'h0000_07d0;
        kick(m);
        @(negedge core_clk);
        chk(spd_mag() === {1'b0, switch_search_speed} && accel_cmd === homing_acceleration, "search speed");
        chk(torque_scale_cmd === normal_torque_scale && follow_error_enable === 1'b1, "non-block torque");
        run_to_load(v2);
        chk(v2 === 1'b1, "index speed unused");
        chk(position_load === 1'b1 && position_load_value === home_offset_value, "zero offset");
        chk(homing_done === 1'b1 && absolute_move_allowed === 1'b1, "search done");
        $display("test search %0d finished", m);
    endtask
    task automatic t_overrun();
        homing_max_travel = 32'h0000_0064;
        kick(M_CAM_NEG);
        for (int i = 0; i < 200 && overrun_error !== 1'b1; i++) @(negedge core_clk);
        chk(overrun_error === 1'b1 && speed_cmd === 17'sh0_0000, "overrun stop");
        chk(homing_done === 1'b0, "done after overrun");
        $display("test overrun finished");
    endtask
    task automatic t_block(input logic signed [7:0] m);
        bit v2;
        homing_max_travel = 32'h0000_0028;
        kick(m);
        @(negedge core_clk);
        chk(follow_error_enable === 1'b0 && torque_scale_cmd === homing_torque_scale, "block torque");
        run_to_load(v2);
        chk(position_load === 1'b1 && position_load_value === home_offset_value, "block zero");
        @(negedge core_clk);
        chk(follow_error_enable === 1'b1 && torque_scale_cmd === normal_torque_scale, "torque restore");
        $display("test block %0d finished", m);
    endtask
    task automatic t_reference();
        kick(M_SET_REFERENCE);
        @(negedge core_clk);
        chk(homing_done === 1'b1 && homing_backup_position === actual_position, "reference stored");
        power_up_start = 1'b1;
        @(negedge core_clk);
        power_up_start = 1'b0;
        for (int i = 0; i < 5 && position_load !== 1'b1; i++) @(negedge core_clk);
        chk(position_load === 1'b1 && position_load_value === home_offset_value, "reference restore");
        $display("test reference finished");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        @(negedge core_clk);
        t_invalid();
        t_absolute(M_ABS_OFFSET, home_offset_value);
        t_absolute(M_ABS_ENCODER, 32'sh0000_1334);
        t_search(M_SWITCH_NEG);
        t_search(M_SWITCH_POS);
        t_search(M_CAM_POS);
        t_overrun();
        t_block(M_BLOCK_ZP_POS);
        t_block(M_BLOCK_POS);
        t_reference();
        report_and_stop();
    end
endmodule
